// ==== rtl/link_packet_fifo_with_cpu_port.sv ====
// How it works
// - Control and bulk traffic use separate storage.
// - Bulk buffer holds two max async packets.
// - Direction input makes bulk buffer transmit/receive.
// - Bulk buffer streams words storage to bus, or bus to storage.
// - Control buffer links processor and bus.
// - Control transmit/receive parts have fixed size.
// - Four lanes read pops next receive quadlet.
// - Same lane read twice also pops.
// - Four lanes written pushes transmit quadlet.
// - Same lane written twice pushes, zeros filled.
// - Bulk never over/underflows; errors flagged.
// - Long requests cut within alignment limits.
`timescale 1ns/1ps
`include "lpf_regs.svh"

// ----------------------------------------
// Synchronous FIFO used by every partition
// ----------------------------------------
module sfifo #(
  parameter int W = 32,
  parameter int D = 2
) (
  input  wire logic         clk,        // Core clock
  input  wire logic         rst_n,      // Synced reset, low active
  input  wire logic         ce,         // Clock enable
  input  wire logic         in_valid,   // Write request
  output logic              in_ready,   // Room for a word
  input  wire logic [W-1:0] in_data,    // Write word
  output logic              out_valid,  // Word available
  input  wire logic         out_ready,  // Read request
  output logic [W-1:0]      out_data    // Head word
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] FULL_C = (AW + 1)'(D);
  localparam logic [AW-1:0] LAST_C = AW'(D - 1);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;

  // Full and empty fall straight out of the count
  assign in_ready  = (cnt_r != FULL_C);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];

  // Storage array carries no reset
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wp_r] <= in_data;
    end
  end

  // Pointers wrap explicitly so D need not be a power of two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) wp_r <= (wp_r == LAST_C) ? '0 : wp_r + 1'b1;
      if (pop)  rp_r <= (rp_r == LAST_C) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : sfifo

// ----------------------------------------
// Top: bulk path, control ports, splitter
// ----------------------------------------
module link_packet_fifo_with_cpu_port
  import lpf_pkg::*;
#(
  parameter int DATA_WORDS = `DATA_FIFO_WORDS,
  parameter int CRX_WORDS  = `CTL_RX_WORDS,
  parameter int CTX_WORDS  = `CTL_TX_WORDS
) (
  input  wire logic        ref_clk,        // 50 MHz core clock
  input  wire logic        resetn,         // Async reset, low active
  input  wire logic        clk_en,         // Low freezes all state but the reset stages
  input  wire dir_e        dir,            // Bulk direction
  input  wire logic        stor_in_valid,  // Storage word offered
  output logic             stor_in_ready,  // Storage word taken
  input  wire logic [31:0] stor_in_data,   // Storage word
  output logic             stor_out_valid, // Word to storage
  input  wire logic        stor_out_ready, // Storage accepts
  output logic [31:0]      stor_out_data,  // Word to storage
  input  wire logic        bus_in_valid,   // Bus word offered
  output logic             bus_in_ready,   // Bus word taken
  input  wire logic [31:0] bus_in_data,    // Bus word
  output logic             bus_out_valid,  // Word to packetizer
  input  wire logic        bus_out_ready,  // Packetizer accepts
  output logic [31:0]      bus_out_data,   // Word to packetizer
  output logic             bulk_full,      // Bulk buffer full
  output logic             bulk_empty,     // Bulk buffer empty
  output logic             xfer_err,       // Sticky transfer error
  input  wire logic        err_clr,        // Clears xfer_err
  input  wire logic        crx_in_valid,   // Received quadlet
  output logic             crx_in_ready,   // Receive part has room
  input  wire logic [31:0] crx_in_data,    // Received quadlet
  output logic             ctx_out_valid,  // Outgoing quadlet
  input  wire logic        ctx_out_ready,  // Packetizer takes it
  output logic [31:0]      ctx_out_data,   // Outgoing quadlet
  output logic             crx_full,       // Receive part full
  output logic             crx_empty,      // Receive part empty
  output logic             ctx_full,       // Transmit part full
  output logic             ctx_empty,      // Transmit part empty
  input  wire cpu_acc_s    cpu,            // Processor byte access
  output logic [7:0]       cpu_rdata,      // Read byte, next cycle
  output logic             rxq_valid,      // Receive port loaded
  input  wire logic        req_valid,      // Long request offered
  output logic             req_ready,      // Splitter idle
  input  wire logic [47:0] req_addr,       // Start address
  input  wire logic [31:0] req_len,        // Length in bytes
  input  wire logic [3:0]  req_max_pay,    // Payload code, 4<<n B
  input  wire logic [1:0]  req_spd,        // Speed code
  output logic             txn_valid,      // Transaction ready
  input  wire logic        txn_ready,      // Transaction taken
  output txn_s             txn             // Address and size
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_q1;
  logic rst_n;

  // Two stages so release never lands mid-edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  function automatic logic [3:0] lane_dec(input logic [1:0] l);
    lane_dec = 4'h1 << l;
  endfunction : lane_dec

  function automatic logic [31:0] put_byte(input logic [31:0] q,
                                           input logic [1:0] l,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = q;
    r[8*l +: 8] = b;
    put_byte = r;
  endfunction : put_byte

  function automatic logic [31:0] min32(input logic [31:0] a,
                                        input logic [31:0] b);
    min32 = (a < b) ? a : b;
  endfunction : min32

  // ----------------------------------------
  // Bulk data path
  // ----------------------------------------
  wire        is_tx = (dir == DIR_TX);
  logic       df_in_ready;
  logic       df_out_valid;
  logic [31:0] df_out_data;
  logic       sk_in_ready;
  logic       sk_out_valid;
  logic [31:0] sk_out_data;
  wire        sk_out_ready = is_tx ? bus_out_ready : stor_out_ready;
  wire        df_in_valid  = is_tx ? stor_in_valid : bus_in_valid;
  wire [31:0] df_in_data   = is_tx ? stor_in_data : bus_in_data;

  // Fill side follows direction; ready only when room, never overflow
  assign stor_in_ready  = is_tx & df_in_ready;
  assign bus_in_ready   = ~is_tx & df_in_ready;
  assign bus_out_valid  = is_tx & sk_out_valid;
  assign stor_out_valid = ~is_tx & sk_out_valid;
  assign bus_out_data   = sk_out_data;
  assign stor_out_data  = sk_out_data;
  assign bulk_full      = ~df_in_ready;
  assign bulk_empty     = ~df_out_valid;

  // Own array, sized for two full packets at the top rate
  sfifo #(.W(32), .D(DATA_WORDS)) u_data (
    .clk(ref_clk), .rst_n(rst_n), .ce(clk_en),
    .in_valid(df_in_valid), .in_ready(df_in_ready),
    .in_data(df_in_data), .out_valid(df_out_valid),
    .out_ready(sk_in_ready), .out_data(df_out_data));

  // Staging pair keeps a word when the drain stalls
  sfifo #(.W(32), .D(`SKID_WORDS)) u_skid (
    .clk(ref_clk), .rst_n(rst_n), .ce(clk_en),
    .in_valid(df_out_valid), .in_ready(sk_in_ready),
    .in_data(df_out_data), .out_valid(sk_out_valid),
    .out_ready(sk_out_ready), .out_data(sk_out_data));

  // ----------------------------------------
  // Transfer error detection
  // ----------------------------------------
  dir_e dir_r;
  logic err_r;
  wire  dir_chg = (dir != dir_r);
  wire  busy    = df_out_valid | sk_out_valid;
  wire  stray   = is_tx ? bus_in_valid : stor_in_valid;
  wire  err_set = (dir_chg & busy) | stray;

  assign xfer_err = err_r;

  // Turning the buffer round with data inside loses words
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_r <= DIR_TX;
      err_r <= 1'b0;
    end else if (clk_en) begin
      dir_r <= dir;
      err_r <= err_set | (err_r & ~err_clr);
    end
  end

  // ----------------------------------------
  // Control receive port
  // ----------------------------------------
  logic        crx_out_valid;
  logic [31:0] crx_out_data;
  logic [31:0] rxq_r;
  logic        rxq_vld_r;
  logic [3:0]  rmask_r;
  logic [7:0]  rdata_r;
  wire  [3:0]  lb      = lane_dec(cpu.lane);
  wire         rd_hit  = cpu.rd & rxq_vld_r;
  wire         rd_agn  = rd_hit & |(rmask_r & lb);
  wire         rd_all  = rd_hit & ((rmask_r | lb) == `LANE_ALL);
  wire         rx_adv  = rd_agn | rd_all;
  wire         rx_load = ~rxq_vld_r & crx_out_valid;

  assign crx_full  = ~crx_in_ready;
  assign crx_empty = ~crx_out_valid;
  assign cpu_rdata = rdata_r;
  assign rxq_valid = rxq_vld_r;

  // Fixed receive part, separate array from the bulk path
  sfifo #(.W(32), .D(CRX_WORDS)) u_crx (
    .clk(ref_clk), .rst_n(rst_n), .ce(clk_en),
    .in_valid(crx_in_valid), .in_ready(crx_in_ready),
    .in_data(crx_in_data), .out_valid(crx_out_valid),
    .out_ready(~rxq_vld_r), .out_data(crx_out_data));

  // Port refills one cycle after it empties; empty port reads zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxq_r     <= 32'h0;
      rxq_vld_r <= 1'b0;
      rmask_r   <= 4'h0;
      rdata_r   <= 8'h0;
    end else if (clk_en) begin
      if (cpu.rd) rdata_r <= rd_hit ? rxq_r[8*cpu.lane +: 8] : 8'h0;
      if (rx_adv) begin
        rxq_vld_r <= 1'b0;
        rmask_r   <= 4'h0;
      end else if (rd_hit) begin
        rmask_r <= rmask_r | lb;
      end else if (rx_load) begin
        rxq_r     <= crx_out_data;
        rxq_vld_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Control transmit port
  // ----------------------------------------
  logic        ctx_in_ready;
  logic [31:0] txq_r;
  logic [3:0]  tmask_r;
  wire         wr_agn = cpu.wr & |(tmask_r & lb);
  wire         wr_all = cpu.wr & ~wr_agn &
                        ((tmask_r | lb) == `LANE_ALL);
  wire  [31:0] txq_m  = put_byte(txq_r, cpu.lane, cpu.wdata);
  wire         ctx_in_valid = wr_all | wr_agn;
  wire  [31:0] ctx_in_data  = wr_all ? txq_m : txq_r;

  assign ctx_full  = ~ctx_in_ready;
  assign ctx_empty = ~ctx_out_valid;

  // A push into a full part is dropped by the FIFO itself
  sfifo #(.W(32), .D(CTX_WORDS)) u_ctx (
    .clk(ref_clk), .rst_n(rst_n), .ce(clk_en),
    .in_valid(ctx_in_valid), .in_ready(ctx_in_ready),
    .in_data(ctx_in_data), .out_valid(ctx_out_valid),
    .out_ready(ctx_out_ready), .out_data(ctx_out_data));

  // Repeated lane ships the partial quadlet, new byte starts the next
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txq_r   <= 32'h0;
      tmask_r <= 4'h0;
    end else if (clk_en) begin
      if (wr_all) begin
        txq_r   <= 32'h0;
        tmask_r <= 4'h0;
      end else if (wr_agn) begin
        txq_r   <= put_byte(32'h0, cpu.lane, cpu.wdata);
        tmask_r <= lb;
      end else if (cpu.wr) begin
        txq_r   <= txq_m;
        tmask_r <= tmask_r | lb;
      end
    end
  end

  // ----------------------------------------
  // Transfer splitter
  // ----------------------------------------
  split_e      spl_r;
  logic [47:0] s_addr_r;
  logic [31:0] s_rem_r;
  logic [31:0] s_lim_r;
  logic        txn_vld_r;
  txn_s        txn_r;
  wire  [1:0]  spd    = (req_spd > `SPD_MAX_CODE) ? `SPD_MAX_CODE
                                                  : req_spd;
  wire  [31:0] lim_in = min32(32'h4 << req_max_pay,
                              `SPD_BASE_BYTES << spd);
  wire  [31:0] room   = s_lim_r - (s_addr_r[31:0] & (s_lim_r - 32'h1));
  wire  [31:0] sz     = min32(s_rem_r, room);
  wire         adv    = ~txn_vld_r | txn_ready;

  assign req_ready = (spl_r == SPL_IDLE);
  assign txn_valid = txn_vld_r;
  assign txn       = txn_r;

  // Each piece stops at the next s_lim_r boundary, the lesser of payload and speed limits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spl_r     <= SPL_IDLE;
      s_addr_r  <= 48'h0;
      s_rem_r   <= 32'h0;
      s_lim_r   <= 32'h4;
      txn_vld_r <= 1'b0;
      txn_r     <= '0;
    end else if (clk_en) begin
      unique case (spl_r)
        SPL_IDLE: begin
          if (req_valid) begin
            spl_r    <= SPL_RUN;
            s_addr_r <= req_addr;
            s_rem_r  <= req_len;
            s_lim_r  <= lim_in;
          end
        end
        SPL_RUN: begin
          if (adv && s_rem_r == 32'h0) begin
            spl_r     <= SPL_IDLE;
            txn_vld_r <= 1'b0;
          end else if (adv) begin
            txn_vld_r <= 1'b1;
            txn_r     <= '{addr: s_addr_r, size: sz[15:0]};
            s_addr_r  <= s_addr_r + {16'h0, sz};
            s_rem_r   <= s_rem_r - sz;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  bulk_noovf_a: assert property (bulk_full |-> !stor_in_ready && !bus_in_ready)
    else $error("bulk buffer accepts while full");
  dir_route_a: assert property (!is_tx |-> !bus_out_valid && !stor_in_ready)
    else $error("bulk path not steered by direction");
  rx_pop4_a: assert property (clk_en && rd_all |=> !rxq_vld_r)
    else $error("receive port kept after four lanes read");
  rx_pop2_a: assert property (clk_en && rd_agn |=> !rxq_vld_r && rmask_r == 4'h0)
    else $error("receive port kept after repeated lane");
  tx_push4_a: assert property (wr_all |-> ctx_in_valid && ctx_in_data == txq_m)
    else $error("four lane write not queued");
  tx_zero_a: assert property (clk_en && wr_agn && !cpu.rd |=> tmask_r == $past(lb))
    else $error("repeated lane did not restart quadlet");
  xerr_set_a: assert property (clk_en && err_set |=> xfer_err)
    else $error("transfer error not flagged");
  split_size_a: assert property (txn_valid |-> txn.size != 16'h0 && 32'(txn.size) <= s_lim_r)
    else $error("transaction size outside limit");
  rx_empty_a: assert property (crx_empty |-> ##1 !$rose(rxq_vld_r))
    else $error("receive port loaded from empty part");
endmodule : link_packet_fifo_with_cpu_port

// ==== rtl/lpf_pkg.sv ====
package lpf_pkg;
  // Bulk buffer direction
  typedef enum logic {
    DIR_TX = 1'b0,   // Storage side fills, bus side drains
    DIR_RX = 1'b1    // Bus side fills, storage side drains
  } dir_e;
  // Transfer splitter state
  typedef enum logic {
    SPL_IDLE = 1'b0,
    SPL_RUN  = 1'b1
  } split_e;
  // One processor byte access to a quadlet port
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] lane;
    logic [7:0] wdata;
  } cpu_acc_s;
  // One bus transaction cut from a long request
  typedef struct packed {
    logic [47:0] addr;
    logic [15:0] size;
  } txn_s;
endpackage : lpf_pkg

// ==== rtl/lpf_regs.svh ====
`ifndef LPF_REGS_SVH
`define LPF_REGS_SVH
// Largest asynchronous payload at the top bus rate, in bytes
`define MAX_ASY_BYTES 2048
// Bulk buffer holds two such packets, in 32-bit words
`define DATA_FIFO_WORDS (2 * `MAX_ASY_BYTES / 4)
// Fixed control partitions, in quadlets
`define CTL_RX_WORDS 32
`define CTL_TX_WORDS 32
// Output staging buffer depth
`define SKID_WORDS 2
// Payload limit at the slowest speed code, bytes
`define SPD_BASE_BYTES 32'h200
// Highest speed code that is honoured
`define SPD_MAX_CODE 2'h2
// Lane mask with every byte lane seen
`define LANE_ALL 4'hF
`endif

// ==== test/far_sink.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Far-side word sink with stall control
// ----------------------------------------
module far_sink (
  input  wire logic        clk,   // Core clock
  input  wire logic        hold,  // Stall fully while high
  input  wire logic        valid, // Word offered
  output logic             ready, // Word accepted
  input  wire logic [31:0] data   // Offered word
);
  logic [31:0] got [0:15];
  int          n = 0;
  logic        ph = 1'b0;
  initial ready = 1'b0;
  // Every other cycle when free, so staging sees a slow receiver
  always @(negedge clk) begin
    ph    <= ~ph;
    ready <= !hold && ph;
  end
  // Record accepted words in order for the bench to inspect
  always @(posedge clk) begin
    if (valid && ready && n < 16) begin
      got[n] <= data;
      n      <= n + 1;
    end
  end
endmodule : far_sink

// ==== test/tb_link_packet_fifo_with_cpu_port.sv ====
`timescale 1ns/1ps
`include "lpf_regs.svh"
module tb_link_packet_fifo_with_cpu_port;
  import lpf_pkg::*;
  localparam int DW = 8;
  localparam int CW = 4;
  typedef struct packed {
    logic [47:0] a;
    logic [31:0] l;
    logic [3:0]  p;
    logic [1:0]  s;
    logic [3:0]  c;
  } row_s;
  // ----------------------------------------
  // Splitter rows: request and transaction count
  // ----------------------------------------
  row_s rows [4] = '{'{48'h0, 32'h400, 4'h9, 2'h0, 4'h2},
                     '{48'h10, 32'h30, 4'h3, 2'h2, 4'h2},
                     '{48'h100, 32'h900, 4'hA, 2'h3, 4'h2},
                     '{48'h40, 32'h0, 4'h2, 2'h1, 4'h0}};
  logic ref_clk = 0, resetn = 0, clk_en = 1, err_clr = 0;
  dir_e dir = DIR_TX;
  logic stor_in_valid = 0, bus_in_valid = 0, crx_in_valid = 0;
  logic [31:0] stor_in_data = 0, bus_in_data = 0, crx_in_data = 0;
  logic stor_in_ready, bus_in_ready, crx_in_ready, req_ready, txn_valid;
  logic stor_out_valid, stor_out_ready, bus_out_valid, bus_out_ready;
  logic [31:0] stor_out_data, bus_out_data, ctx_out_data;
  logic bulk_full, bulk_empty, xfer_err, ctx_out_valid, ctx_out_ready;
  logic crx_full, crx_empty, ctx_full, ctx_empty, rxq_valid;
  cpu_acc_s cpu = '0;
  logic [7:0] cpu_rdata;
  logic req_valid = 0, txn_ready = 0, hold_b = 1, ok;
  logic [47:0] req_addr = 0, a;
  logic [31:0] req_len = 0, r, sz, q;
  logic [3:0] req_max_pay = 0;
  logic [1:0] req_spd = 0;
  txn_s txn;
  int n_fail = 0, check_count = 0, cycles = 0, taken, n;
  logic [1:0] wl [9] = '{2'h3, 2'h1, 2'h0, 2'h2, 2'h1, 2'h1, 2'h0, 2'h2,
                         2'h3};
  logic [7:0] wb [9] = '{8'hA3, 8'hA1, 8'hA0, 8'hA2, 8'h5C, 8'h7E,
                         8'h01, 8'h02, 8'h03};
  logic [31:0] wq [3] = '{32'hA3A2A1A0, 32'h00005C00, 32'h03027E01};

  link_packet_fifo_with_cpu_port #(.DATA_WORDS(DW), .CRX_WORDS(CW),
    .CTX_WORDS(4)) DUT (.ref_clk(ref_clk), .resetn(resetn),
    .clk_en(clk_en), .dir(dir), .stor_in_valid(stor_in_valid),
    .stor_in_ready(stor_in_ready), .stor_in_data(stor_in_data),
    .stor_out_valid(stor_out_valid), .stor_out_ready(stor_out_ready),
    .stor_out_data(stor_out_data), .bus_in_valid(bus_in_valid),
    .bus_in_ready(bus_in_ready), .bus_in_data(bus_in_data),
    .bus_out_valid(bus_out_valid), .bus_out_ready(bus_out_ready),
    .bus_out_data(bus_out_data), .bulk_full(bulk_full),
    .bulk_empty(bulk_empty), .xfer_err(xfer_err), .err_clr(err_clr),
    .crx_in_valid(crx_in_valid), .crx_in_ready(crx_in_ready),
    .crx_in_data(crx_in_data), .ctx_out_valid(ctx_out_valid),
    .ctx_out_ready(ctx_out_ready), .ctx_out_data(ctx_out_data),
    .crx_full(crx_full), .crx_empty(crx_empty), .ctx_full(ctx_full),
    .ctx_empty(ctx_empty), .cpu(cpu), .cpu_rdata(cpu_rdata),
    .rxq_valid(rxq_valid), .req_valid(req_valid), .req_ready(req_ready),
    .req_addr(req_addr), .req_len(req_len), .req_max_pay(req_max_pay),
    .req_spd(req_spd), .txn_valid(txn_valid), .txn_ready(txn_ready),
    .txn(txn));
  // Three sinks: packetizer data, storage drain, packetizer control
  far_sink snk_b (.clk(ref_clk), .hold(hold_b), .valid(bus_out_valid),
    .ready(bus_out_ready), .data(bus_out_data));
  far_sink snk_s (.clk(ref_clk), .hold(1'b0), .valid(stor_out_valid),
    .ready(stor_out_ready), .data(stor_out_data));
  far_sink snk_c (.clk(ref_clk), .hold(1'b0), .valid(ctx_out_valid),
    .ready(ctx_out_ready), .data(ctx_out_data));

  always #10 ref_clk = ~ref_clk;
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk_val(input logic [47:0] g, input logic [47:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask : chk_val
  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : tick
  // Offer one word on side 0 storage, 1 bus, 2 control receive
  task automatic push(input int side, input logic [31:0] d,
                      output logic rdy);
    @(negedge ref_clk);
    stor_in_valid = (side == 0);
    bus_in_valid  = (side == 1);
    crx_in_valid  = (side == 2);
    stor_in_data  = d;
    bus_in_data   = d;
    crx_in_data   = d;
    #1 rdy = (side == 0) ? stor_in_ready :
             (side == 1) ? bus_in_ready : crx_in_ready;
  endtask : push
  task automatic idle();
    @(negedge ref_clk);
    stor_in_valid = 0;
    bus_in_valid  = 0;
    crx_in_valid  = 0;
  endtask : idle
  task automatic cpu_op(input logic w, input logic [1:0] ln,
                        input logic [7:0] d);
    @(negedge ref_clk);
    cpu = '{rd: !w, wr: w, lane: ln, wdata: d};
    @(negedge ref_clk);
    cpu = '0;
  endtask : cpu_op
  task automatic wait_rxq(input logic v);
    for (int i = 0; i < 20 && rxq_valid !== v; i++) @(negedge ref_clk);
  endtask : wait_rxq
  function automatic logic [31:0] cut(input logic [47:0] ad,
    input logic [31:0] rem, input logic [3:0] p, input logic [1:0] s);
    logic [31:0] pl, sl, lim, room;
    pl   = 32'h4 << p;
    sl   = 32'h200 << ((s == 2'h3) ? 2'h2 : s);
    lim  = (pl < sl) ? pl : sl;
    room = lim - (ad[31:0] % lim);
    return (rem < room) ? rem : room;
  endfunction : cut
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tick(4);
    resetn = 1;
    tick(4);
    chk_val({bulk_empty, crx_empty, ctx_empty, xfer_err}, 4'hE);
    for (int k = 0; k < 4; k++) begin
      @(negedge ref_clk);
      {req_valid, req_addr, req_len} = {1'b1, rows[k].a, rows[k].l};
      {req_max_pay, req_spd} = {rows[k].p, rows[k].s};
      @(negedge ref_clk);
      req_valid = 0;
      {a, r} = {rows[k].a, rows[k].l};
      for (n = 0; n < 6; n++) begin
        for (int i = 0; i < 40 && txn_valid !== 1; i++) tick(1);
        if (txn_valid !== 1) break;
        sz = cut(a, r, rows[k].p, rows[k].s);
        chk_val(txn.addr, a);
        chk_val(txn.size, sz);
        chk_val(req_ready, 0);
        txn_ready = 1;
        @(negedge ref_clk);
        txn_ready = 0;
        a = a + sz;
        r = r - sz;
      end
      chk_val(n, rows[k].c);
      chk_val(req_ready, 1);
    end
    $display("splitter rows done");
    taken = 0;
    for (int i = 0; i < 16; i++) begin
      push(0, 32'h100 + i, ok);
      if (ok !== 1) break;
      taken++;
    end
    idle();
    chk_val(taken, DW + `SKID_WORDS);
    chk_val({bulk_full, stor_in_ready, xfer_err}, 3'h4);
    hold_b = 0;
    for (int i = 0; i < 200 && snk_b.n < taken; i++) tick(1);
    for (int i = 0; i < taken; i++) chk_val(snk_b.got[i], 32'h100 + i);
    chk_val({snk_b.n, bulk_empty}, {taken, 1'b1});
    @(negedge ref_clk);
    bus_in_valid = 1;
    #1 chk_val(bus_in_ready, 0);
    idle();
    tick(1);
    chk_val(xfer_err, 1);
    err_clr = 1;
    @(negedge ref_clk);
    err_clr = 0;
    chk_val(xfer_err, 0);
    $display("bulk transmit done");
    dir = DIR_RX;
    for (int i = 0; i < 3; i++) push(1, 32'h200 + i, ok);
    idle();
    chk_val(stor_in_ready, 0);
    for (int i = 0; i < 100 && snk_s.n < 3; i++) tick(1);
    for (int i = 0; i < 3; i++) chk_val(snk_s.got[i], 32'h200 + i);
    chk_val({snk_s.n, bulk_empty}, {32'd3, 1'b1});
    chk_val(snk_b.n, taken);
    $display("bulk receive done");
    // Stray word while frozen must not flag until the clock runs again
    @(negedge ref_clk);
    {clk_en, stor_in_valid} = 2'h1;
    tick(2);
    chk_val(xfer_err, 0);
    clk_en = 1;
    idle();
    chk_val(xfer_err, 1);
    err_clr = 1;
    tick(1);
    err_clr = 0;
    $display("clock enable done");
    push(2, 32'h11223344, ok);
    push(2, 32'h55667788, ok);
    idle();
    wait_rxq(1);
    q = 32'h11223344;
    for (int l = 0; l < 4; l++) begin
      cpu_op(1'b0, 2'(l), 8'h0);
      chk_val(cpu_rdata, q[8*l +: 8]);
    end
    wait_rxq(0);
    wait_rxq(1);
    cpu_op(1'b0, 2'h2, 8'h0);
    chk_val(cpu_rdata, 8'h66);
    cpu_op(1'b0, 2'h2, 8'h0);
    chk_val(cpu_rdata, 8'h66);
    wait_rxq(0);
    tick(4);
    chk_val({rxq_valid, crx_empty}, 2'h1);
    cpu_op(1'b0, 2'h0, 8'h0);
    chk_val(cpu_rdata, 0);
    // Port takes one quadlet, the part CW more, then refuses
    taken = 0;
    for (int i = 0; i < 8; i++) begin
      push(2, 32'hC0 + i, ok);
      if (ok !== 1) break;
      taken++;
    end
    idle();
    chk_val({taken, crx_full, crx_in_ready}, {CW + 1, 2'h2});
    cpu_op(1'b0, 2'h0, 8'h0);
    chk_val(cpu_rdata, 8'hC0);
    $display("control receive done");
    for (int i = 0; i < 9; i++) cpu_op(1'b1, wl[i], wb[i]);
    for (int i = 0; i < 100 && snk_c.n < 3; i++) tick(1);
    for (int i = 0; i < 3; i++) chk_val(snk_c.got[i], wq[i]);
    chk_val(snk_c.n, 3);
    chk_val({ctx_empty, ctx_full}, 2'h2);
    $display("control transmit done");
    // Second reset mid-run must empty the full receive part and the port
    resetn = 0;
    tick(2);
    resetn = 1;
    tick(3);
    chk_val({bulk_empty, crx_empty, rxq_valid, xfer_err}, 4'hC);
    $display("mid-run reset done");
    end_of_test();
  end
endmodule : tb_link_packet_fifo_with_cpu_port
